/* File: rtl/gpc_pkg.sv */
package gpc_pkg;

  // control word layout
  localparam int GPC_WORD_W = 32;
  localparam int GPC_PAD_IN_BIT = 24;
  localparam int GPC_ALT_BIT = 16;
  localparam int GPC_MUX_LSB = 12;
  localparam int GPC_POL_BIT = 11;
  localparam int GPC_SRC_BIT = 10;
  localparam int GPC_DIR_BIT = 9;
  localparam int GPC_BUF_BIT = 8;
  localparam int GPC_EDGE_BIT = 7;
  localparam int GPC_INTDET_LSB = 4;
  localparam int GPC_PWRG_LSB = 2;

  // writable bits: 16, 13:12, 11:2; everything else except the pad status bit 24 reads zero
  localparam logic [31:0] GPC_WR_MASK = 32'h0001_3ffc;
  // value of the stored word after reset
  localparam logic [31:0] GPC_CTRL_RESET = 32'h0000_0000;
  // flip-flops in the reset release chain
  localparam int GPC_RST_STAGES = 2;

  // active signal function of the pin
  typedef enum logic [1:0] {
    GPC_FUNC_GPIO,
    GPC_FUNC_SIG1,
    GPC_FUNC_SIG2,
    GPC_FUNC_SIG3
  } gpc_func_type;

  // conditional inversion, shared by the output and interrupt paths
  function automatic logic gpc_pol(input logic value, input logic invert);
    return value ^ invert;
  endfunction

endpackage

/* File: rtl/gpc_rst_sync.sv */
`timescale 1ns/10ps
module gpc_rst_sync import gpc_pkg::*; (
  input wire logic clk_i,
  input wire logic rstn_i,
  output logic rstn_o
);

  logic [GPC_RST_STAGES-1:0] chain_reg;

  // asserts at once, releases after the chain fills with ones
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      chain_reg <= '0;
    end else begin
      chain_reg <= {chain_reg[GPC_RST_STAGES-2:0], 1'b1};
    end
  end

  assign rstn_o = chain_reg[GPC_RST_STAGES-1];

endmodule

/* File: rtl/gpc_pin_mux.sv */
`timescale 1ns/10ps
module gpc_pin_mux import gpc_pkg::*; #(
  parameter int NUM_FUNC = 3
) (
  input wire gpc_func_type func_sel_i,
  input wire logic pol_i,
  input wire logic src_sel_i,
  input wire logic dir_i,
  input wire logic open_drain_i,
  input wire logic alt_data_i,
  input wire logic out_reg_bit_i,
  input wire logic [NUM_FUNC-1:0] func_out_i,
  input wire logic [NUM_FUNC-1:0] func_oe_i,
  output logic pin_data_o,
  output logic pin_oe_o
);

  logic data;
  logic oe;
  logic [1:0] idx;

  // pick data and direction from gpio logic or the selected function
  always_comb begin
    idx = 2'(func_sel_i) - 2'h1;
    if (func_sel_i == GPC_FUNC_GPIO) begin
      data = src_sel_i ? out_reg_bit_i : alt_data_i;
      oe = dir_i;
    end else begin
      data = gpc_pol(func_out_i[idx], pol_i);
      oe = func_oe_i[idx];
    end
    pin_data_o = data;
    // open drain never drives a high level
    pin_oe_o = oe && (!open_drain_i || !data);
  end

endmodule

/* File: rtl/gpc_pin_ctrl.sv */
`timescale 1ns/10ps
module gpc_pin_ctrl import gpc_pkg::*; #(
  parameter int NUM_FUNC = 3,
  parameter int NUM_WELLS = 4
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic wr_en_i,
  input wire logic [GPC_WORD_W-1:0] wr_data_i,
  output logic [GPC_WORD_W-1:0] rd_data_o,
  input wire logic out_reg_bit_i,
  input wire logic [NUM_WELLS-1:0] well_on_i,
  input wire logic [NUM_FUNC-1:0] func_out_i,
  input wire logic [NUM_FUNC-1:0] func_oe_i,
  input wire logic pad_in_i,
  output logic pad_out_o,
  output logic pad_oe_o,
  output logic pad_level_o,
  output logic edge_en_o,
  output logic [2:0] int_det_o,
  output logic int_sense_inv_o,
  output logic open_drain_o
);

  logic rst_n;
  logic [GPC_WORD_W-1:0] ctrl_reg;
  logic [GPC_WORD_W-1:0] ctrl_next;
  logic [GPC_WORD_W-1:0] rd_next;
  gpc_func_type func_sel;
  logic pol;
  logic src_sel;
  logic dir;
  logic open_drain;
  logic alt_data;
  logic [1:0] pwr_gate;
  logic well_off;
  logic pad_bit;
  logic pin_data;
  logic pin_oe;

  // main_well_reset enters here and leaves through the release chain
  gpc_rst_sync u_rst_sync (
    .clk_i(clk_sys_i),
    .rstn_i(rstn_i),
    .rstn_o(rst_n)
  );

  // field views of the stored word
  assign func_sel = gpc_func_type'(ctrl_reg[GPC_MUX_LSB +: 2]);
  assign pol = ctrl_reg[GPC_POL_BIT];
  assign src_sel = ctrl_reg[GPC_SRC_BIT];
  assign dir = ctrl_reg[GPC_DIR_BIT];
  assign open_drain = ctrl_reg[GPC_BUF_BIT];
  assign alt_data = ctrl_reg[GPC_ALT_BIT];
  assign pwr_gate = ctrl_reg[GPC_PWRG_LSB +: 2];

  // the gating field names the well this pad lives on
  assign well_off = !well_on_i[pwr_gate];

  // pad status, raw level, forced high on a dead well
  assign pad_bit = well_off ? 1'b1 : pad_in_i;

  // only writable fields are stored; the rest are held at zero
  assign ctrl_next = wr_data_i & GPC_WR_MASK;

  // word store, written whole on each strobe
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= GPC_CTRL_RESET & GPC_WR_MASK;
    end else if (wr_en_i) begin
      ctrl_reg <= ctrl_next;
    end
  end

  // read image: stored fields plus the live pad bit
  always_comb begin
    rd_next = ctrl_reg;
    rd_next[GPC_PAD_IN_BIT] = pad_bit;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_o <= GPC_CTRL_RESET & GPC_WR_MASK;
    end else begin
      rd_data_o <= rd_next;
    end
  end

  // output source and direction selection
  gpc_pin_mux #(
    .NUM_FUNC(NUM_FUNC)
  ) u_pin_mux (
    .func_sel_i(func_sel),
    .pol_i(pol),
    .src_sel_i(src_sel),
    .dir_i(dir),
    .open_drain_i(open_drain),
    .alt_data_i(alt_data),
    .out_reg_bit_i(out_reg_bit_i),
    .func_out_i(func_out_i),
    .func_oe_i(func_oe_i),
    .pin_data_o(pin_data),
    .pin_oe_o(pin_oe)
  );

  // pad drive registered so the pad sees clean edges
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pad_out_o <= 1'b0;
      pad_oe_o <= 1'b0;
    end else begin
      pad_out_o <= pin_data;
      pad_oe_o <= pin_oe;
    end
  end

  // level for the shared input register, never inverted
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pad_level_o <= 1'b0;
    end else begin
      pad_level_o <= pad_in_i;
    end
  end

  // settings handed to the edge and interrupt detector
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      edge_en_o <= 1'b0;
      int_det_o <= 3'h0;
      int_sense_inv_o <= 1'b0;
      open_drain_o <= 1'b0;
    end else begin
      edge_en_o <= ctrl_reg[GPC_EDGE_BIT];
      int_det_o <= ctrl_reg[GPC_INTDET_LSB +: 3];
      int_sense_inv_o <= gpc_pol(1'b0, pol && (func_sel != GPC_FUNC_GPIO));
      open_drain_o <= open_drain;
    end
  end

  // checks on the registered behaviour
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n);

  // helper: counts edges since reset release, saturating at three
  logic [1:0] up_cnt;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      up_cnt <= 2'h0;
    end else if (up_cnt != 2'h3) begin
      up_cnt <= up_cnt + 2'h1;
    end
  end

  sequence write_alt_s;
    wr_en_i ##1 1'b1;
  endsequence

  sequence gpio_alt_out_s;
    (func_sel == GPC_FUNC_GPIO) && !src_sel && dir;
  endsequence

  // non-gpio function in charge of the pin
  sequence func_any_s;
    func_sel != GPC_FUNC_GPIO;
  endsequence

  // gpio mode with the shared output register as data source
  sequence gpio_reg_out_s;
    (func_sel == GPC_FUNC_GPIO) && src_sel;
  endsequence

  pad_read_a: assert property (
    (up_cnt == 2'h3) && !well_off |=> rd_data_o[GPC_PAD_IN_BIT] == $past(pad_in_i)
  ) else $error("pad status bit does not follow the pad");

  well_off_a: assert property (
    well_off |=> rd_data_o[GPC_PAD_IN_BIT]
  ) else $error("pad status bit not forced high on dead well");

  alt_drive_a: assert property (
    gpio_alt_out_s |=> pad_out_o == $past(alt_data)
  ) else $error("pin does not follow alternate data");

  alt_block_a: assert property (
    (func_sel == GPC_FUNC_GPIO) && src_sel |=> pad_out_o == $past(out_reg_bit_i)
  ) else $error("alternate data reached the pin while disabled");

  alt_readback_a: assert property (
    write_alt_s |=> rd_data_o[GPC_ALT_BIT] == $past(wr_data_i[GPC_ALT_BIT], 2)
  ) else $error("alternate data readback differs from write");

  func_two_a: assert property (
    (func_sel == GPC_FUNC_SIG2) |=> pad_out_o == ($past(func_out_i[1]) ^ $past(pol))
  ) else $error("function two not routed to the pin");

  func_invert_a: assert property (
    pol && (func_sel == GPC_FUNC_SIG1) |=> pad_out_o != $past(func_out_i[0])
  ) else $error("function output not inverted");

  sense_inv_a: assert property (
    pol && (func_sel != GPC_FUNC_GPIO) |=> int_sense_inv_o
  ) else $error("interrupt sense not inverted");

  gpio_nopol_a: assert property (
    pol && (func_sel == GPC_FUNC_GPIO) && !src_sel |=> pad_out_o == $past(alt_data)
  ) else $error("polarity changed gpio output");

  level_raw_a: assert property (
    (up_cnt != 2'h0) |-> pad_level_o == $past(pad_in_i)
  ) else $error("input register level inverted or stale");

  src_sel_a: assert property (
    (func_sel == GPC_FUNC_GPIO) && !src_sel |=> pad_out_o != $past(out_reg_bit_i)
      || $past(out_reg_bit_i) == $past(alt_data)
  ) else $error("source select picked the wrong data");

  dir_gpio_a: assert property (
    (func_sel == GPC_FUNC_GPIO) && !open_drain |=> pad_oe_o == $past(dir)
  ) else $error("direction bit ignored in gpio mode");

  dir_func_a: assert property (
    (func_sel == GPC_FUNC_SIG3) && !open_drain |=> pad_oe_o == $past(func_oe_i[2])
  ) else $error("function did not control direction");

  reserved_a: assert property (
    ((rd_data_o & ~GPC_WR_MASK) & ~(32'h0000_0001 << GPC_PAD_IN_BIT)) == 32'h0000_0000
  ) else $error("reserved bits read nonzero");

  // routing of signal functions one and three, with and without inversion
  func_one_a: assert property (
    (func_sel == GPC_FUNC_SIG1) |=> pad_out_o == ($past(func_out_i[0]) ^ $past(pol))
  ) else $error("function one not routed to the pin");

  func_three_a: assert property (
    (func_sel == GPC_FUNC_SIG3) |=> pad_out_o == ($past(func_out_i[2]) ^ $past(pol))
  ) else $error("function three not routed to the pin");

  invert_three_a: assert property (
    pol && (func_sel == GPC_FUNC_SIG3) |=> pad_out_o != $past(func_out_i[2])
  ) else $error("function three output not inverted");

  sense_plain_a: assert property (
    (func_sel == GPC_FUNC_GPIO) || !pol |=> !int_sense_inv_o
  ) else $error("interrupt sense inverted without cause");

  // gpio data paths with the alternate bit low, masked, or polarity set
  alt_low_a: assert property (
    gpio_alt_out_s ##0 !alt_data |=> !pad_out_o
  ) else $error("alternate data zero did not drive low");

  alt_mask_a: assert property (
    gpio_reg_out_s ##0 $changed(alt_data) |=> pad_out_o == $past(out_reg_bit_i)
  ) else $error("masked alternate data reached the pin");

  nopol_reg_a: assert property (
    gpio_reg_out_s ##0 pol |=> pad_out_o == $past(out_reg_bit_i)
  ) else $error("polarity changed gpio register output");

  // direction and drive under the selected function
  dir_one_a: assert property (
    (func_sel == GPC_FUNC_SIG1) && !open_drain |=> pad_oe_o == $past(func_oe_i[0])
  ) else $error("function one did not control direction");

  dir_two_a: assert property (
    (func_sel == GPC_FUNC_SIG2) && !open_drain |=> pad_oe_o == $past(func_oe_i[1])
  ) else $error("function two did not control direction");

  drain_high_a: assert property (
    open_drain |=> !(pad_oe_o && pad_out_o)
  ) else $error("open drain pin drove a high level");

  // stored word and read image
  word_store_a: assert property (
    wr_en_i |=> ctrl_reg == ($past(wr_data_i) & GPC_WR_MASK)
  ) else $error("write stored a reserved bit or lost a field");

  word_hold_a: assert property (
    !wr_en_i |=> ctrl_reg == $past(ctrl_reg)
  ) else $error("stored word changed without a write");

  read_image_a: assert property (
    1'b1 |=> (rd_data_o & GPC_WR_MASK) == $past(ctrl_reg)
  ) else $error("read image differs from the stored word");

  // input views, independent of source select and polarity
  pad_src_a: assert property (
    src_sel && !well_off |=> rd_data_o[GPC_PAD_IN_BIT] == $past(pad_in_i)
  ) else $error("pad status bit depends on source select");

  level_func_a: assert property (
    func_any_s ##0 pol |=> pad_level_o == $past(pad_in_i)
  ) else $error("input register level inverted by polarity");

endmodule

/* File: sim/gpc_pad_model.sv */
`timescale 1ns/10ps
module gpc_pad_model (
  input wire logic pad_out_i,
  input wire logic pad_oe_i,
  input wire logic ext_level_i,
  output logic pad_in_o
);
  // pad level: the pin's own driver wins, else the outside source
  assign pad_in_o = pad_oe_i ? pad_out_i : ext_level_i;
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  import gpc_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b1;
  logic wr_en = 1'b0;
  logic [31:0] wr_data = 32'h0;
  logic [31:0] rd_data;
  logic out_reg = 1'b0;
  logic [3:0] well_on = 4'hf;
  logic [2:0] func_out = 3'h0;
  logic [2:0] func_oe = 3'h0;
  logic ext = 1'b0;
  logic pad_in, pad_out, pad_oe, pad_level, int_inv;
  logic edge_en, open_drain;
  logic [2:0] int_det;
  int mismatches = 0;
  int cmp_count = 0;

  // 50 MHz system clock
  always #10 clk_sys_i = ~clk_sys_i;

  gpc_pin_ctrl dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .wr_en_i(wr_en),
    .wr_data_i(wr_data), .rd_data_o(rd_data), .out_reg_bit_i(out_reg),
    .well_on_i(well_on), .func_out_i(func_out), .func_oe_i(func_oe),
    .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
    .pad_level_o(pad_level), .edge_en_o(edge_en), .int_det_o(int_det),
    .int_sense_inv_o(int_inv), .open_drain_o(open_drain));

  gpc_pad_model pad (.pad_out_i(pad_out), .pad_oe_i(pad_oe), .ext_level_i(ext),
    .pad_in_o(pad_in));

  // builds a control word from its fields
  function automatic logic [31:0] cw(input logic [1:0] mux, input logic pol,
      input logic src, input logic dir, input logic alt, input logic [1:0] pw);
    return {15'h0, alt, 2'h0, mux, pol, src, dir, 5'h0, pw, 2'h0};
  endfunction

  // one write pulse, then wait until the new fields are visible
  task automatic wr(input logic [31:0] w);
    @(posedge clk_sys_i);
    #1 wr_en = 1'b1;
    wr_data = w;
    @(posedge clk_sys_i);
    #1 wr_en = 1'b0;
    @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    #1;
  endtask

  task automatic step();
    @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    #1;
  endtask

  // stored bits, reserved bits and read-back of the alternate data
  task automatic t_regs();
    wr(32'hffff_ffff);
    `CHK(rd_data, 32'h0001_3ffc)
    `CHK({edge_en, int_det, open_drain}, 5'h1f)
    wr(cw(2'h0, 1'b0, 1'b1, 1'b1, 1'b1, 2'h0));
    `CHK(rd_data[16], 1'b1)
    `CHK(pad_out, 1'b0)
    wr(32'h0000_0000);
    `CHK(rd_data, 32'h0)
    `CHK({edge_en, int_det, open_drain}, 5'h00)
  endtask

  // pad input view, uninverted, forced high while the well is off
  task automatic t_pad();
    wr(cw(2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0));
    ext = 1'b1;
    step();
    `CHK(rd_data[24], 1'b1)
    `CHK(pad_level, 1'b1)
    ext = 1'b0;
    step();
    `CHK(rd_data[24], 1'b0)
    ext = 1'b1;
    wr(cw(2'h1, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0));
    `CHK(rd_data[24], 1'b1)
    `CHK(pad_level, 1'b1)
    ext = 1'b0;
    well_on = 4'hb;
    wr(cw(2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h2));
    `CHK(rd_data[24], 1'b1)
    well_on = 4'hf;
    step();
    `CHK(rd_data[24], 1'b0)
  endtask

  // gpio output path: source select, alternate data, direction, polarity
  task automatic t_gpio();
    wr(cw(2'h0, 1'b0, 1'b0, 1'b1, 1'b1, 2'h0));
    `CHK(pad_out, 1'b1)
    `CHK(pad_oe, 1'b1)
    out_reg = 1'b1;
    wr(cw(2'h0, 1'b1, 1'b0, 1'b1, 1'b0, 2'h0));
    `CHK(pad_out, 1'b0)
    wr(cw(2'h0, 1'b0, 1'b1, 1'b1, 1'b0, 2'h0));
    `CHK(pad_out, 1'b1)
    out_reg = 1'b0;
    wr(cw(2'h0, 1'b0, 1'b1, 1'b1, 1'b1, 2'h0));
    `CHK(pad_out, 1'b0)
    wr(cw(2'h0, 1'b0, 1'b1, 1'b0, 1'b1, 2'h0));
    `CHK(pad_oe, 1'b0)
    // open drain with edge and detect fields set: a high level is never driven
    wr(cw(2'h0, 1'b0, 1'b0, 1'b1, 1'b1, 2'h0) | 32'h0000_01d0);
    `CHK({edge_en, int_det, open_drain}, 5'h1b)
    `CHK(pad_oe, 1'b0)
    wr(cw(2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0) | 32'h0000_01d0);
    `CHK(pad_oe, 1'b1)
    `CHK(pad_out, 1'b0)
  endtask

  // every signal function with both polarities
  task automatic t_func();
    func_out = 3'b001;
    func_oe = 3'b010;
    for (int m = 1; m < 4; m++) begin
      for (int p = 0; p < 2; p++) begin
        wr(cw(m[1:0], p[0], 1'b0, 1'b1, 1'b0, 2'h0));
        `CHK(pad_out, func_out[m-1] ^ p[0])
        `CHK(pad_oe, func_oe[m-1])
        `CHK(int_inv, p[0])
      end
    end
    wr(cw(2'h0, 1'b1, 1'b0, 1'b1, 1'b0, 2'h0));
    `CHK(int_inv, 1'b0)
  endtask

  task automatic final_report();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // reset, then the scenarios
  // reset is entered by a falling edge so the asynchronous path takes it at once
  initial begin
    #1 rstn_i = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1;
    `CHK(rd_data, 32'h0)
    rstn_i = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    t_regs();
    t_pad();
    t_gpio();
    t_func();
    final_report();
  end
endmodule
